// ---- dac_cmd_consts.svh ----
`ifndef DAC_CMD_CONSTS_SVH
`define DAC_CMD_CONSTS_SVH

// ==========================================================
// Serial frame layout
`define FRAME_BITS        24
`define FRAME_LAST_BIT    5'h17
`define BIT_STRAP_HI      23
`define BIT_STRAP_LO      22
`define BIT_LOAD_HI       21
`define BIT_LOAD_LO       20
`define BIT_SEL_HI        18
`define BIT_SEL_LO        17
`define BIT_PD_FLAG       16
`define BIT_MODE_HI       15
`define BIT_MODE_LO       14
`define BIT_REF_HI        13
`define BIT_REF_LO        12

// ==========================================================
// Field encodings
`define LOAD_NONE         2'h0
`define LOAD_SINGLE       2'h1
`define LOAD_ALL          2'h2
`define LOAD_BCAST        2'h3
`define SEL_BCAST         2'h2
`define PD_NORMAL         2'h0
`define PD_1K             2'h1
`define PD_100K           2'h2
`define PD_HIZ            2'h3
`define REFCMD_AUTO       2'h0
`define REFCMD_ON         2'h1
`define REFCMD_OFF        2'h2

// ==========================================================
// Pin synchroniser: {strap_lo, strap_hi, sdin, sclk, frame_sel_n}
`define SYNC_WIDTH        3
`define SYNC_RESET        5'h01
`define PIN_FSEL_N        0
`define PIN_SCLK          1
`define PIN_SDIN          2
`define PIN_STRAP_HI      3
`define PIN_STRAP_LO      4

// ==========================================================
// Register map (byte addresses)
`define OFS_CTRL          5'h00
`define OFS_STATUS        5'h04
`define OFS_CODE_AB       5'h08
`define OFS_CODE_CD       5'h0C
`define OFS_PD_MODES      5'h10
`define CTRL_LINK_EN      0
`define CTRL_CLR_OVF      1
`define CTRL_RESET        1'h1
`define CODE_RESET        16'h0000

`endif

// ---- dac_cmd_pkg.sv ----
package dac_cmd_pkg;

    typedef enum logic [1:0] {
        REF_AUTO,
        REF_FORCED_ON,
        REF_FORCED_OFF
    } ref_mode_t;

    typedef enum logic {
        DEC_IDLE,
        DEC_APPLY
    } dec_state_t;

    typedef logic [23:0] frame_t;

endpackage

// ---- frame_skid_fifo.sv ----
`timescale 1ns/100ps
module frame_skid_fifo #(
    parameter int WIDTH = 24
) (
    input  wire logic             sys_clk,   // System clock
    input  wire logic             rst,       // Synchronous reset
    input  wire logic [WIDTH-1:0] in_data,   // Word to store
    input  wire logic             in_valid,  // Word offered
    output logic                  in_ready,  // Room for a word
    output logic      [WIDTH-1:0] out_data,  // Oldest word, registered
    output logic                  out_valid, // Oldest word present
    input  wire logic             out_ready  // Consumer takes word
);

    logic [WIDTH-1:0] head_reg;
    logic [WIDTH-1:0] tail_reg;
    logic [1:0]       count_reg;
    logic             push;
    logic             pop;

    assign in_ready  = (count_reg != 2'h2);
    assign out_valid = (count_reg != 2'h0);
    assign out_data  = head_reg;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            count_reg <= 2'h0;
        end else if (push && !pop) begin
            count_reg <= count_reg + 2'h1;
        end else if (pop && !push) begin
            count_reg <= count_reg - 2'h1;
        end
    end

    // Head always holds the oldest word so reads need no mux
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            head_reg <= '0;
        end else if (pop) begin
            head_reg <= (count_reg == 2'h2) ? tail_reg : in_data;
        end else if (push && count_reg == 2'h0) begin
            head_reg <= in_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tail_reg <= '0;
        end else if (push && count_reg == 2'h1 && !pop) begin
            tail_reg <= in_data;
        end
    end

endmodule

// ---- quad_dac_command_decoder.sv ----
// Overview of operation
// - A frame completes and takes effect at its 24th serial clock falling edge.
// - Load bits 10 store the selected buffer, then load all four outputs.
// - Load bits 01 store the selected buffer and load only that output.
// - Load bits 00 store the buffer only; outputs wait for a later load.
// - Power-down flag with mode 01 selects 1k to ground.
// - Power-down flag with mode 10 selects 100k to ground.
// - Load bits 11 with select 10 writes the code to all channels, loads all.
// - Same broadcast with power-down flag applies the mode to all channels.
// - Reference frame with bits 01 forces the reference on.
// - Reference frame with bits 10 forces the reference off.
// - Reference frame with bits 00 restores automatic reference mode.
// - Automatic mode powers reference down when every channel is powered down.
// - Automatic mode powers reference up when a load makes a channel normal.
// - Forced off keeps the reference down until another reference frame.
// - Stored codes survive power-down; flag 0 means normal operation.
//
// Implementation choices: the Avalon-MM register port and the address map.
`timescale 1ns/100ps
`include "dac_cmd_consts.svh"
module quad_dac_command_decoder
    import dac_cmd_pkg::*;
(
    input  wire logic              sys_clk,         // System clock, 10 MHz
    input  wire logic              rst,             // Synchronous reset
    input  wire logic              frame_sel_n,     // Frame select pin
    input  wire logic              sclk,            // Serial clock pin
    input  wire logic              sdin,            // Serial data pin
    input  wire logic              addr_strap_high, // Upper address strap
    input  wire logic              addr_strap_low,  // Lower address strap
    input  wire logic [4:0]        avs_address,     // Byte address
    input  wire logic              avs_read,        // Read request
    input  wire logic              avs_write,       // Write request
    input  wire logic [31:0]       avs_writedata,   // Write data
    input  wire logic [3:0]        avs_byteenable,  // Byte lanes
    output logic      [31:0]       avs_readdata,    // Read data
    output logic                   avs_waitrequest, // Stall
    output logic      [3:0][15:0]  dac_code,        // Output codes
    output logic      [3:0][1:0]   dac_pd_mode,     // Output power modes
    output logic                   ref_on           // Internal reference powered
);

    // ==========================================================
    // Pin synchronisers
    logic [4:0] pin_s1_reg;
    logic [4:0] pin_s2_reg;
    logic [4:0] pin_s3_reg;
    logic [4:0] pin_filt_reg;
    logic       sclk_last_reg;
    logic       sclk_fall;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pin_s1_reg <= `SYNC_RESET;
            pin_s2_reg <= `SYNC_RESET;
            pin_s3_reg <= `SYNC_RESET;
        end else begin
            pin_s1_reg <= {addr_strap_low, addr_strap_high, sdin, sclk, frame_sel_n};
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
        end
    end

    // A change counts only once two late stages agree
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pin_filt_reg <= `SYNC_RESET;
        end else begin
            for (int i = 0; i < 5; i++) begin
                if (pin_s2_reg[i] == pin_s3_reg[i]) begin
                    pin_filt_reg[i] <= pin_s2_reg[i];
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sclk_last_reg <= 1'b0;
        end else begin
            sclk_last_reg <= pin_filt_reg[`PIN_SCLK];
        end
    end

    assign sclk_fall = sclk_last_reg && !pin_filt_reg[`PIN_SCLK];

    // ==========================================================
    // Frame shifter
    logic [22:0] shift_reg;
    logic [4:0]  bit_cnt_reg;
    logic        frame_done;
    logic        frame_valid_reg;
    frame_t      frame_data_reg;
    logic        link_en_reg;
    logic        fifo_in_ready;

    // Bits past the 24th are dropped; the frame already took effect
    assign frame_done = sclk_fall && !pin_filt_reg[`PIN_FSEL_N] && link_en_reg
                        && bit_cnt_reg == `FRAME_LAST_BIT;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bit_cnt_reg <= 5'h00;
            shift_reg   <= '0;
        end else if (pin_filt_reg[`PIN_FSEL_N]) begin
            bit_cnt_reg <= 5'h00;
        end else if (sclk_fall && bit_cnt_reg < 5'(`FRAME_BITS)) begin
            shift_reg   <= {shift_reg[21:0], pin_filt_reg[`PIN_SDIN]};
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            frame_valid_reg <= 1'b0;
            frame_data_reg  <= '0;
        end else begin
            frame_valid_reg <= frame_done;
            if (frame_done) begin
                frame_data_reg <= {shift_reg, pin_filt_reg[`PIN_SDIN]};
            end
        end
    end

    // ==========================================================
    // Two-entry buffer toward the decoder
    frame_t     cmd_head;
    logic       cmd_valid;
    dec_state_t state_reg;

    frame_skid_fifo #(
        .WIDTH     (24)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .in_data   (frame_data_reg),
        .in_valid  (frame_valid_reg),
        .in_ready  (fifo_in_ready),
        .out_data  (cmd_head),
        .out_valid (cmd_valid),
        .out_ready (state_reg == DEC_IDLE)
    );

    // ==========================================================
    // Command decode
    frame_t     cmd_reg;
    logic       apply;
    logic       addr_ok;
    logic [1:0] ld;
    logic [1:0] sel;
    logic [1:0] mode;
    logic       pd_flag;
    logic       is_ref;
    logic       is_bcast;
    logic       data_ok;
    logic [1:0] new_pd;
    logic [3:0] wr_mask;
    logic [3:0] load_mask;

    function automatic logic [3:0] chan_onehot(input logic [1:0] s);
        chan_onehot = 4'h1 << s;
    endfunction

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= DEC_IDLE;
            cmd_reg   <= '0;
        end else begin
            case (state_reg)
                DEC_IDLE: begin
                    if (cmd_valid) begin
                        cmd_reg   <= cmd_head;
                        state_reg <= DEC_APPLY;
                    end
                end
                DEC_APPLY: state_reg <= DEC_IDLE;
                default:   state_reg <= DEC_IDLE;
            endcase
        end
    end

    assign apply    = (state_reg == DEC_APPLY);
    assign addr_ok  = cmd_reg[`BIT_STRAP_HI] == pin_filt_reg[`PIN_STRAP_HI]
                      && cmd_reg[`BIT_STRAP_LO] == pin_filt_reg[`PIN_STRAP_LO];
    assign ld       = cmd_reg[`BIT_LOAD_HI:`BIT_LOAD_LO];
    assign sel      = cmd_reg[`BIT_SEL_HI:`BIT_SEL_LO];
    assign mode     = cmd_reg[`BIT_MODE_HI:`BIT_MODE_LO];
    assign pd_flag  = cmd_reg[`BIT_PD_FLAG];
    // Of the low data bits of these frames only bits 13:12 reach the decode
    assign is_ref   = pd_flag && ld == `LOAD_NONE && sel == 2'h0
                      && mode == `PD_NORMAL;
    assign is_bcast = (ld == `LOAD_BCAST) && (sel == `SEL_BCAST);
    assign data_ok  = addr_ok && !is_ref && (!pd_flag || mode != `PD_NORMAL)
                      && (ld != `LOAD_BCAST || is_bcast);
    assign new_pd   = pd_flag ? mode : `PD_NORMAL;
    assign wr_mask  = is_bcast ? 4'hF : chan_onehot(sel);
    assign load_mask = (ld == `LOAD_ALL || is_bcast) ? 4'hF :
                       (ld == `LOAD_SINGLE) ? chan_onehot(sel) :
                       4'h0;

    // ==========================================================
    // Channel buffers and outputs
    logic [3:0][15:0] buf_code_reg;
    logic [3:0][1:0]  buf_pd_reg;
    logic [3:0][15:0] buf_code_next;
    logic [3:0][1:0]  buf_pd_next;

    always_comb begin
        buf_code_next = buf_code_reg;
        buf_pd_next   = buf_pd_reg;
        for (int i = 0; i < 4; i++) begin
            if (apply && data_ok && wr_mask[i]) begin
                buf_pd_next[i] = new_pd;
                // Power-down frames leave the stored code alone
                if (!pd_flag) begin
                    buf_code_next[i] = cmd_reg[15:0];
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            buf_code_reg <= {4{`CODE_RESET}};
            buf_pd_reg   <= {4{`PD_NORMAL}};
        end else begin
            buf_code_reg <= buf_code_next;
            buf_pd_reg   <= buf_pd_next;
        end
    end

    // Loads read the buffer as updated by the same frame
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dac_code    <= {4{`CODE_RESET}};
            dac_pd_mode <= {4{`PD_NORMAL}};
        end else if (apply && data_ok) begin
            for (int i = 0; i < 4; i++) begin
                if (load_mask[i]) begin
                    dac_code[i]    <= buf_code_next[i];
                    dac_pd_mode[i] <= buf_pd_next[i];
                end
            end
        end
    end

    // ==========================================================
    // Internal reference control
    ref_mode_t ref_mode_reg;
    logic      any_normal;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ref_mode_reg <= REF_AUTO;
        end else if (apply && addr_ok && is_ref) begin
            case (cmd_reg[`BIT_REF_HI:`BIT_REF_LO])
                `REFCMD_AUTO: ref_mode_reg <= REF_AUTO;
                `REFCMD_ON:   ref_mode_reg <= REF_FORCED_ON;
                `REFCMD_OFF:  ref_mode_reg <= REF_FORCED_OFF;
                default:      ref_mode_reg <= ref_mode_reg;
            endcase
        end
    end

    always_comb begin
        any_normal = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (dac_pd_mode[i] == `PD_NORMAL) begin
                any_normal = 1'b1;
            end
        end
    end

    // Follows the loaded power modes one cycle later
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ref_on <= 1'b1;
        end else begin
            ref_on <= (ref_mode_reg == REF_FORCED_ON)
                      || (ref_mode_reg == REF_AUTO && any_normal);
        end
    end

    // ==========================================================
    // Bus slave
    logic       overflow_reg;
    logic [7:0] frame_count_reg;
    logic       bus_req;
    logic       bus_take;
    logic [31:0] read_value;

    assign bus_req  = avs_read || avs_write;
    assign bus_take = bus_req && !avs_waitrequest;

    // One wait state per access, then a single answer cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !(bus_req && avs_waitrequest);
        end
    end

    always_comb begin
        case (avs_address)
            `OFS_CTRL:     read_value = {31'h0000_0000, link_en_reg};
            `OFS_STATUS:   read_value = {16'h0000, frame_count_reg, 4'h0, overflow_reg,
                                         ref_mode_reg, ref_on};
            `OFS_CODE_AB:  read_value = {dac_code[1], dac_code[0]};
            `OFS_CODE_CD:  read_value = {dac_code[3], dac_code[2]};
            `OFS_PD_MODES: read_value = {24'h00_0000, dac_pd_mode};
            default:       read_value = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= read_value;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            link_en_reg <= `CTRL_RESET;
        end else if (bus_take && avs_write && avs_address == `OFS_CTRL
                     && avs_byteenable[0]) begin
            link_en_reg <= avs_writedata[`CTRL_LINK_EN];
        end
    end

    // A drop in the clearing cycle still leaves the flag set
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            overflow_reg <= 1'b0;
        end else if (frame_valid_reg && !fifo_in_ready) begin
            overflow_reg <= 1'b1;
        end else if (bus_take && avs_write && avs_address == `OFS_CTRL
                     && avs_byteenable[0] && avs_writedata[`CTRL_CLR_OVF]) begin
            overflow_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            frame_count_reg <= 8'h00;
        end else if (apply && addr_ok) begin
            frame_count_reg <= frame_count_reg + 8'h01;
        end
    end

    // ==========================================================
    // Assertions
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_apply_ok;
        apply && data_ok;
    endsequence

    a_frame_at_24th: assert property (frame_valid_reg |-> $past(bit_cnt_reg) == 5'h17)
        else $error("frame accepted at wrong bit count");
    a_load_all_out: assert property (s_apply_ok and (ld == `LOAD_ALL) |=> dac_code == buf_code_reg)
        else $error("simultaneous load missed a channel");
    a_single_load_out: assert property (s_apply_ok and (ld == `LOAD_SINGLE)
        |=> dac_code[$past(sel)] == buf_code_reg[$past(sel)]
            && dac_pd_mode[$past(sel)] == buf_pd_reg[$past(sel)])
        else $error("single load did not reach its output");
    a_store_only_hold: assert property (apply && ld == `LOAD_NONE |=> $stable(dac_code))
        else $error("buffer-only write changed outputs");
    a_pd_mode_store: assert property (s_apply_ok and pd_flag and !is_bcast
        |=> buf_pd_reg[$past(sel)] == $past(mode))
        else $error("power-down mode not stored");
    a_bcast_all: assert property (s_apply_ok and is_bcast and !pd_flag
        |=> dac_code[0] == $past(cmd_reg[15:0]) && dac_code[3] == $past(cmd_reg[15:0]))
        else $error("broadcast code not applied to all");
    a_bcast_pd_all: assert property (s_apply_ok and is_bcast and pd_flag
        |=> dac_pd_mode[1] == $past(mode) && dac_pd_mode[2] == $past(mode))
        else $error("broadcast power-down not applied to all");
    a_ref_force_on: assert property (apply && addr_ok && is_ref
        && cmd_reg[13:12] == `REFCMD_ON |=> ref_mode_reg == REF_FORCED_ON ##1 ref_on)
        else $error("reference not forced on");
    a_ref_stays_off: assert property ((ref_mode_reg == REF_FORCED_OFF) [*2] |-> !ref_on)
        else $error("reference powered while forced off");
    a_ref_auto_down: assert property ((ref_mode_reg == REF_AUTO && !any_normal) [*2]
        |-> !ref_on)
        else $error("reference stayed up with all channels down");
    a_code_kept_pd: assert property (s_apply_ok and pd_flag
        |=> buf_code_reg == $past(buf_code_reg))
        else $error("power-down frame altered stored code");
    a_strap_reject: assert property (apply && !addr_ok
        |=> $stable(buf_code_reg) && $stable(ref_mode_reg))
        else $error("frame with foreign address was applied");
    a_bus_one_wait: assert property (bus_req && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer not given after one wait");

endmodule

// ---- serial_host.sv ----
`timescale 1ns/100ps
module serial_host
    import dac_cmd_pkg::*;
(
    input  wire logic sys_clk,     // System clock
    output logic      frame_sel_n, // Frame select, low in frame
    output logic      sclk,        // Serial clock, still outside frames
    output logic      sdin         // Serial data
);
    initial begin
        frame_sel_n = 1'b1;
        sclk        = 1'b0;
        sdin        = 1'b0;
    end

    // =========================================================
    // Frame sender
    // Half period of four system clocks; the decoder accepts any slower rate
    task automatic send_frame(input frame_t f, input int nbits);
        int i;
        @(posedge sys_clk);
        frame_sel_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
        for (i = 23; i > 23 - nbits; i--) begin
            sclk <= 1'b1;
            sdin <= f[i];
            repeat (4) @(posedge sys_clk);
            sclk <= 1'b0;
            repeat (4) @(posedge sys_clk);
        end
        frame_sel_n <= 1'b1;
        // Released line shows the inverse, so a held value cannot pass
        sdin        <= ~sdin;
        repeat (4) @(posedge sys_clk);
    endtask
endmodule

// ---- testbench.sv ----
`timescale 1ns/100ps
`include "dac_cmd_consts.svh"
module testbench
    import dac_cmd_pkg::*;
;
    logic             sys_clk, rst, frame_sel_n, sclk, sdin, strap_hi, strap_lo;
    logic             avs_read, avs_write, avs_waitrequest, ref_on, link_en;
    logic [4:0]       avs_address;
    logic [31:0]      avs_writedata, avs_readdata, rd;
    logic [3:0]       avs_byteenable;
    logic [3:0][15:0] dac_code;
    logic [3:0][1:0]  dac_pd_mode;
    logic [15:0]      exp_code [4], bcode [4], r;
    logic [1:0]       exp_pd [4], bpd [4], rmode;
    int               fail_count, total_checks, seed, m, applied;
    frame_t           f;

    quad_dac_command_decoder i_quad_dac_command_decoder (
        .sys_clk(sys_clk), .rst(rst), .frame_sel_n(frame_sel_n), .sclk(sclk), .sdin(sdin),
        .addr_strap_high(strap_hi), .addr_strap_low(strap_lo), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .dac_code(dac_code), .dac_pd_mode(dac_pd_mode),
        .ref_on(ref_on));
    serial_host i_serial_host (.sys_clk(sys_clk), .frame_sel_n(frame_sel_n), .sclk(sclk),
        .sdin(sdin));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // =========================================================
    // Expectation model
    function automatic void model_apply(input frame_t x);
        logic [1:0] ld, sel, md;
        logic       pd;
        ld  = x[21:20];
        sel = x[18:17];
        pd  = x[16];
        md  = x[15:14];
        if (x[23:22] !== {strap_hi, strap_lo} || !link_en) return;
        applied++;
        if (pd && ld == 2'h0 && sel == 2'h0 && md == 2'h0) begin
            if (x[13:12] != 2'h3) rmode = x[13:12];
            return;
        end
        if ((pd && md == 2'h0) || (ld == 2'h3 && sel != 2'h2)) return;
        for (int i = 0; i < 4; i++) begin
            if (ld == 2'h3 || i == sel) begin
                if (!pd) bcode[i] = x[15:0];
                bpd[i] = pd ? md : 2'h0;
            end
            if (ld[1] || (ld == 2'h1 && i == sel)) begin
                exp_code[i] = bcode[i];
                exp_pd[i]   = bpd[i];
            end
        end
    endfunction

    function automatic frame_t mk(input logic [1:0] ld, sel, input logic pd, input logic [15:0] lo);
        return {strap_hi, strap_lo, ld, 1'b0, sel, pd, lo};
    endfunction

    // =========================================================
    // Checks and bus
    task automatic check_val(input string what, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic check_outputs();
        logic e;
        e = (rmode == 2'h1);
        for (int i = 0; i < 4; i++) begin
            check_val("dac_code", 32'(exp_code[i]), 32'(dac_code[i]));
            check_val("dac_pd_mode", 32'(exp_pd[i]), 32'(dac_pd_mode[i]));
            if (rmode == 2'h0 && exp_pd[i] == 2'h0) e = 1'b1;
        end
        check_val("ref_on", 32'(e), 32'(ref_on));
    endtask

    task automatic run(input frame_t x, input int nbits);
        i_serial_host.send_frame(x, nbits);
        if (nbits == 24) model_apply(x);
        repeat (16) @(posedge sys_clk);
        check_outputs();
    endtask

    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= ~wr;
        avs_writedata <= wd;
        // Waitrequest and read data are both taken at one rising edge
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        if (n >= 50) fail_count++;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Far above the roughly ten thousand cycles the sequence needs
    initial begin
        repeat (40000) @(posedge sys_clk);
        fail_count++;
        tally_and_finish();
    end

    initial begin
        seed = 90549;
        fail_count = 0;
        total_checks = 0;
        applied = 0;
        {rst, avs_read, avs_write, avs_address, avs_writedata} = {1'b1, 39'h0};
        avs_byteenable = 4'hF;
        {strap_hi, strap_lo} = 2'($random(seed));
        {link_en, rmode} = 3'h4;
        exp_code = '{default: 16'h0000};
        bcode = '{default: 16'h0000};
        exp_pd = '{default: 2'h0};
        bpd = '{default: 2'h0};
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (6) @(posedge sys_clk);
        check_outputs();
        bus(1'b0, `OFS_STATUS, 32'h0000_0000);
        check_val("status", 32'h0000_0001, {28'h0, rd[3:0]});
        bus(1'b0, 5'h14, 32'h0000_0000);
        check_val("unmapped", 32'h0000_0000, rd);
        $display("test reset done");
        for (m = 0; m < 4; m++) run(mk(2'h1, 2'(m), 1'b0, 16'($random(seed))), 24);
        for (m = 0; m < 3; m++) run(mk(2'h0, 2'(m), 1'b0, 16'($random(seed))), 24);
        run(mk(2'h2, 2'h3, 1'b0, 16'($random(seed))), 24);
        for (m = 1; m < 4; m++) begin
            r = 16'($random(seed));
            run(mk(2'h1, 2'(m), 1'b1, {2'(m), r[13:0]}), 24);
        end
        run(mk(2'h3, 2'h2, 1'b0, 16'($random(seed))), 24);
        run(mk(2'h3, 2'h2, 1'b1, {2'h3, 14'h1A5C}), 24);
        run(mk(2'h1, 2'h0, 1'b0, 16'($random(seed))), 24);
        $display("test loads done");
        run(mk(2'h0, 2'h0, 1'b1, 16'h1ABC), 24);
        run(mk(2'h3, 2'h2, 1'b1, {2'h1, 14'h0000}), 24);
        run(mk(2'h0, 2'h0, 1'b1, 16'h2FFF), 24);
        run(mk(2'h3, 2'h2, 1'b0, 16'($random(seed))), 24);
        run(mk(2'h0, 2'h0, 1'b1, 16'h0123), 24);
        $display("test reference done");
        f = mk(2'h1, 2'h0, 1'b0, 16'($random(seed)));
        f[23] = ~f[23];
        run(f, 24);
        run(mk(2'h1, 2'h2, 1'b0, 16'($random(seed))), 23);
        bus(1'b1, `OFS_CTRL, 32'h0000_0000);
        link_en = 1'b0;
        run(mk(2'h1, 2'h1, 1'b0, 16'($random(seed))), 24);
        bus(1'b1, `OFS_CTRL, 32'h0000_0001);
        link_en = 1'b1;
        $display("test refusals done");
        repeat (20) begin
            f = frame_t'($random(seed));
            f[23:22] = {strap_hi, strap_lo};
            f[19] = 1'b0;
            run(f, 24);
        end
        $display("test random done");
        bus(1'b0, `OFS_STATUS, 32'h0000_0000);
        check_val("frame_count", 32'(applied[7:0]), 32'(rd[15:8]));
        tally_and_finish();
    end
endmodule
